// *** rtl/bcp_engine.sv ***
// Buffer program engine: counted-loop transfer and position store orders
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module bcp_engine #(
	parameter int AW = 15,
	parameter int CW = 12
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [bcp_pkg::BUS_AW-1:0] reg_addr,
	input wire logic [bcp_pkg::BUS_DW-1:0] reg_wr_data,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [bcp_pkg::BUS_DW-1:0] reg_rd_data,
	output var logic [AW-1:0] mem_addr,
	output var logic mem_rd,
	output var logic mem_wr,
	output var logic [bcp_pkg::WORD_W-1:0] mem_wr_data,
	input wire logic [bcp_pkg::WORD_W-1:0] mem_rd_data,
	input wire logic [CW-1:0] beam_x,
	input wire logic [CW-1:0] beam_y,
	input wire logic [CW-1:0] tablet_x,
	input wire logic [CW-1:0] tablet_y,
	input wire logic tip_switch,
	output logic attention,
	output logic tip_switch_indicator
);
	localparam int SW = 2 * CW + 1;

	bcp_ctl_if ctl ();

	bcp_regs u_regs (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.addr(reg_addr),
		.wr_data(reg_wr_data),
		.wr_en(reg_wr),
		.rd_en(reg_rd),
		.rd_data(reg_rd_data),
		.attention(attention),
		.tip_switch_indicator(tip_switch_indicator),
		.ctl(ctl)
	);

	logic [SW-1:0] pins_s;
	logic [CW-1:0] tab_x_s;
	logic [CW-1:0] tab_y_s;
	logic tip_s;

	bcp_sync3 #(
		.W(SW)
	) u_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.d({tip_switch, tablet_y, tablet_x}),
		.q(pins_s)
	);

	assign tab_x_s = pins_s[CW-1:0];
	assign tab_y_s = pins_s[2*CW-1:CW];
	assign tip_s = pins_s[SW-1];

	bcp_pkg::bcp_state_t state_r;
	bcp_pkg::bcp_state_t state_nxt;
	logic [AW-1:0] pc_r;
	logic [AW-1:0] pc_nxt;
	logic [1:0] widx_r;
	logic [1:0] widx_nxt;
	logic [bcp_pkg::WORD_W-1:0] ow_r [0:bcp_pkg::ORDER_WORDS-1];
	logic latch_en;
	logic [AW-1:0] mem_addr_nxt;
	logic mem_rd_nxt;
	logic mem_wr_nxt;
	logic [bcp_pkg::WORD_W-1:0] mem_wr_data_nxt;
	logic err_r;
	logic err_nxt;
	logic stop_pend_r;
	logic branched_r;
	logic branched_nxt;
	logic set_attention_enable_r;
	logic set_attention_enable_nxt;
	logic set_tsi_r;
	logic set_tsi_nxt;
	logic [15:0] order_cnt_r;
	logic [15:0] order_cnt_nxt;

	// Order decode
	logic [bcp_pkg::WORD_W-1:0] code_w;
	logic [bcp_pkg::WORD_W-1:0] opt_w;
	logic is_count;
	logic is_store;
	logic new_code_ok;
	logic [bcp_pkg::WORD_W-1:0] cnt_dec;
	logic cnt_branch;
	logic [AW-1:0] branch_tgt;
	logic [AW-1:0] seq_pc;
	logic [AW-1:0] store_base;
	logic [AW-1:0] cnt_word_addr;
	logic [CW-1:0] pos_x;
	logic [CW-1:0] pos_y;
	logic [bcp_pkg::WORD_W-1:0] x_word;
	logic [bcp_pkg::WORD_W-1:0] y_word;

	assign code_w = ow_r[bcp_pkg::IDX_CODE];
	assign opt_w = ow_r[bcp_pkg::IDX_TARGET];
	assign is_count = code_w == bcp_pkg::OP_XFER_COUNT;
	assign is_store = code_w == bcp_pkg::OP_STORE_POS;
	assign new_code_ok = mem_rd_data == bcp_pkg::OP_XFER_COUNT || mem_rd_data == bcp_pkg::OP_STORE_POS;
	// Unsigned wrap takes a zero count to all ones, which then branches
	assign cnt_dec = ow_r[bcp_pkg::IDX_COUNT] - bcp_pkg::COUNT_STEP;
	assign cnt_branch = cnt_dec != '0;
	assign branch_tgt = ow_r[bcp_pkg::IDX_TARGET][AW:1];
	assign seq_pc = pc_r + AW'(bcp_pkg::ORDER_WORDS);
	assign cnt_word_addr = pc_r + AW'(bcp_pkg::IDX_COUNT);
	assign store_base = ow_r[bcp_pkg::IDX_COUNT][AW:1];
	assign pos_x = opt_w[bcp_pkg::OPT_TABLET] ? tab_x_s : beam_x;
	assign pos_y = opt_w[bcp_pkg::OPT_TABLET] ? tab_y_s : beam_y;

	always_comb begin
		x_word = {{(bcp_pkg::WORD_W-CW){1'b0}}, pos_x};
		x_word[bcp_pkg::BLANK_BIT] = opt_w[bcp_pkg::OPT_BLANK];
		y_word = {{(bcp_pkg::WORD_W-CW){1'b0}}, pos_y};
	end

	always_comb begin
		state_nxt = state_r;
		pc_nxt = pc_r;
		widx_nxt = widx_r;
		latch_en = 1'b0;
		mem_addr_nxt = mem_addr;
		mem_rd_nxt = 1'b0;
		mem_wr_nxt = 1'b0;
		mem_wr_data_nxt = mem_wr_data;
		err_nxt = err_r;
		branched_nxt = branched_r;
		set_attention_enable_nxt = 1'b0;
		set_tsi_nxt = 1'b0;
		order_cnt_nxt = order_cnt_r;
		case (state_r)
			bcp_pkg::S_IDLE: begin
				if (ctl.start) begin
					pc_nxt = ctl.start_addr[AW:1];
					widx_nxt = bcp_pkg::IDX_CODE;
					err_nxt = 1'b0;
					state_nxt = bcp_pkg::S_FETCH;
				end else if (ctl.resume && !err_r) begin
					widx_nxt = bcp_pkg::IDX_CODE;
					state_nxt = bcp_pkg::S_FETCH;
				end
			end
			bcp_pkg::S_FETCH: begin
				mem_rd_nxt = 1'b1;
				mem_addr_nxt = pc_r + AW'(widx_r);
				state_nxt = bcp_pkg::S_WAIT;
			end
			bcp_pkg::S_WAIT: begin
				state_nxt = bcp_pkg::S_LATCH;
			end
			bcp_pkg::S_LATCH: begin
				latch_en = 1'b1;
				if (widx_r == bcp_pkg::IDX_CODE && !new_code_ok) begin
					// Orders outside this engine halt it rather than being skipped blindly
					err_nxt = 1'b1;
					state_nxt = bcp_pkg::S_IDLE;
				end else if (widx_r == bcp_pkg::IDX_COUNT) begin
					state_nxt = bcp_pkg::S_EXEC;
				end else begin
					widx_nxt = widx_r + 2'h1;
					state_nxt = bcp_pkg::S_FETCH;
				end
			end
			bcp_pkg::S_EXEC: begin
				mem_wr_nxt = 1'b1;
				if (is_count) begin
					mem_addr_nxt = cnt_word_addr;
					mem_wr_data_nxt = cnt_dec;
					branched_nxt = cnt_branch;
					state_nxt = bcp_pkg::S_WR_CNT;
				end else begin
					mem_addr_nxt = store_base;
					mem_wr_data_nxt = x_word;
					set_attention_enable_nxt = opt_w[bcp_pkg::OPT_ATTENTION_ENABLE] && tip_s;
					set_tsi_nxt = opt_w[bcp_pkg::OPT_SET_IND];
					state_nxt = bcp_pkg::S_WR_X;
				end
			end
			bcp_pkg::S_WR_CNT: begin
				// Write-back is on the memory port this cycle, ahead of any fetch
				state_nxt = bcp_pkg::S_NEXT;
			end
			bcp_pkg::S_WR_X: begin
				mem_wr_nxt = 1'b1;
				mem_addr_nxt = store_base + AW'(1);
				mem_wr_data_nxt = y_word;
				state_nxt = bcp_pkg::S_WR_Y;
			end
			bcp_pkg::S_WR_Y: begin
				state_nxt = bcp_pkg::S_NEXT;
			end
			bcp_pkg::S_NEXT: begin
				pc_nxt = (is_count && cnt_branch) ? branch_tgt : seq_pc;
				widx_nxt = bcp_pkg::IDX_CODE;
				order_cnt_nxt = order_cnt_r + 16'h0001;
				if (stop_pend_r || ctl.stop || ctl.step_mode) begin
					state_nxt = bcp_pkg::S_IDLE;
				end else begin
					state_nxt = bcp_pkg::S_FETCH;
				end
			end
			default: begin
				state_nxt = bcp_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r <= bcp_pkg::S_IDLE;
			pc_r <= '0;
			widx_r <= '0;
		end else begin
			state_r <= state_nxt;
			pc_r <= pc_nxt;
			widx_r <= widx_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < bcp_pkg::ORDER_WORDS; i++) begin
				ow_r[i] <= '0;
			end
		end else if (latch_en) begin
			ow_r[widx_r] <= mem_rd_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mem_addr <= '0;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_wr_data <= '0;
		end else begin
			mem_addr <= mem_addr_nxt;
			mem_rd <= mem_rd_nxt;
			mem_wr <= mem_wr_nxt;
			mem_wr_data <= mem_wr_data_nxt;
		end
	end

	// A stop is held until the order in flight has finished its writes
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			stop_pend_r <= 1'b0;
		end else if (state_r == bcp_pkg::S_IDLE || state_r == bcp_pkg::S_NEXT) begin
			stop_pend_r <= 1'b0;
		end else if (ctl.stop) begin
			stop_pend_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			err_r <= 1'b0;
			branched_r <= 1'b0;
			set_attention_enable_r <= 1'b0;
			set_tsi_r <= 1'b0;
			order_cnt_r <= '0;
		end else begin
			err_r <= err_nxt;
			branched_r <= branched_nxt;
			set_attention_enable_r <= set_attention_enable_nxt;
			set_tsi_r <= set_tsi_nxt;
			order_cnt_r <= order_cnt_nxt;
		end
	end

	assign ctl.busy = state_r != bcp_pkg::S_IDLE;
	assign ctl.err = err_r;
	assign ctl.branched = branched_r;
	assign ctl.set_attention_enable = set_attention_enable_r;
	assign ctl.set_tsi = set_tsi_r;
	assign ctl.tip = tip_s;
	assign ctl.pc_byte = 16'({pc_r, 1'b0});
	assign ctl.last_op = code_w;
	assign ctl.order_cnt = order_cnt_r;
endmodule : bcp_engine
`default_nettype wire

// *** rtl/bcp_pkg.sv ***
// Shared constants and types for the buffer count loop and position store engine
package bcp_pkg;

	localparam int WORD_W = 16;
	localparam int BUS_AW = 8;
	localparam int BUS_DW = 32;

	localparam logic [15:0] OP_XFER_COUNT = 16'h2af0;
	localparam logic [15:0] OP_STORE_POS = 16'h2ae8;
	localparam logic [15:0] COUNT_STEP = 16'h0001;
	localparam int ORDER_WORDS = 3;
	localparam logic [1:0] IDX_CODE = 2'h0;
	localparam logic [1:0] IDX_TARGET = 2'h1;
	localparam logic [1:0] IDX_COUNT = 2'h2;
	localparam int COUNT_MAX = 32767;

	localparam int OPT_TABLET = 8;
	localparam int OPT_ATTENTION_ENABLE = 7;
	localparam int OPT_SET_IND = 6;
	localparam int OPT_BLANK = 5;
	localparam int BLANK_BIT = 15;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_START = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_PC = 8'h0c;
	localparam logic [7:0] REG_ORDERS = 8'h10;
	localparam logic [7:0] REG_LAST = 8'h14;

	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_CLR_ATTENTION_ENABLE = 2;
	localparam int CTRL_CLR_TSI = 3;
	localparam int CTRL_STEP = 4;
	localparam int CTRL_RESUME = 5;

	localparam int ST_BUSY = 0;
	localparam int ST_ATTENTION_ENABLE = 1;
	localparam int ST_TSI = 2;
	localparam int ST_ERR = 3;
	localparam int ST_TIP = 4;
	localparam int ST_BRANCH = 5;

	typedef enum logic [3:0] {
		S_IDLE,
		S_FETCH,
		S_WAIT,
		S_LATCH,
		S_EXEC,
		S_WR_CNT,
		S_WR_X,
		S_WR_Y,
		S_NEXT
	} bcp_state_t;

endpackage : bcp_pkg

// *** rtl/bcp_ctl_if.sv ***
// Control and status bundle between the order engine and its register file
`timescale 1ns/1ns
`default_nettype none
interface bcp_ctl_if;
	logic start;
	logic resume;
	logic stop;
	logic step_mode;
	logic [15:0] start_addr;
	logic set_attention_enable;
	logic set_tsi;
	logic busy;
	logic err;
	logic branched;
	logic tip;
	logic [15:0] pc_byte;
	logic [15:0] last_op;
	logic [15:0] order_cnt;

	modport eng (
		input start, resume, stop, step_mode, start_addr,
		output set_attention_enable, set_tsi, busy, err, branched, tip, pc_byte, last_op, order_cnt
	);
	modport regs (
		output start, resume, stop, step_mode, start_addr,
		input set_attention_enable, set_tsi, busy, err, branched, tip, pc_byte, last_op, order_cnt
	);
endinterface : bcp_ctl_if
`default_nettype wire

// *** rtl/bcp_sync3.sv ***
// Three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ns
`default_nettype none
module bcp_sync3 #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output var logic [W-1:0] q
);
	// Lanes settle independently; a multi-bit value may be torn for a cycle while it moves
	for (genvar i = 0; i < W; i++) begin : g_lane
		logic [2:0] s;
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				s <= '0;
			end else begin
				s <= {s[1:0], d[i]};
			end
		end
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				q[i] <= 1'b0;
			end else if (s[1] == s[2]) begin
				q[i] <= s[2];
			end
		end
	end
endmodule : bcp_sync3
`default_nettype wire

// *** rtl/bcp_regs.sv ***
// Software register file for the order engine
`timescale 1ns/1ns
`default_nettype none
module bcp_regs (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [bcp_pkg::BUS_AW-1:0] addr,
	input wire logic [bcp_pkg::BUS_DW-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output var logic [bcp_pkg::BUS_DW-1:0] rd_data,
	output var logic attention,
	output var logic tip_switch_indicator,
	bcp_ctl_if.regs ctl
);
	logic hit_ctrl;
	logic hit_start;
	logic hit_status;
	logic hit_pc;
	logic hit_orders;
	logic hit_last;
	logic wr_ctrl;
	logic [bcp_pkg::BUS_DW-1:0] status_word;
	logic [bcp_pkg::BUS_DW-1:0] rd_mux;

	assign hit_ctrl = addr == bcp_pkg::REG_CTRL;
	assign hit_start = addr == bcp_pkg::REG_START;
	assign hit_status = addr == bcp_pkg::REG_STATUS;
	assign hit_pc = addr == bcp_pkg::REG_PC;
	assign hit_orders = addr == bcp_pkg::REG_ORDERS;
	assign hit_last = addr == bcp_pkg::REG_LAST;
	assign wr_ctrl = wr_en && hit_ctrl;

	always_comb begin
		status_word = '0;
		status_word[bcp_pkg::ST_BUSY] = ctl.busy;
		status_word[bcp_pkg::ST_ATTENTION_ENABLE] = attention;
		status_word[bcp_pkg::ST_TSI] = tip_switch_indicator;
		status_word[bcp_pkg::ST_ERR] = ctl.err;
		status_word[bcp_pkg::ST_TIP] = ctl.tip;
		status_word[bcp_pkg::ST_BRANCH] = ctl.branched;
	end

	assign rd_mux = hit_ctrl ? {{(bcp_pkg::BUS_DW-1){1'b0}}, ctl.step_mode} << bcp_pkg::CTRL_STEP :
		hit_start ? {16'h0000, ctl.start_addr} :
		hit_status ? status_word :
		hit_pc ? {16'h0000, ctl.pc_byte} :
		hit_orders ? {16'h0000, ctl.order_cnt} :
		hit_last ? {16'h0000, ctl.last_op} : '0;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rd_data <= '0;
		end else begin
			rd_data <= rd_en ? rd_mux : '0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctl.start <= 1'b0;
			ctl.resume <= 1'b0;
			ctl.stop <= 1'b0;
			ctl.step_mode <= 1'b0;
			ctl.start_addr <= '0;
		end else begin
			ctl.start <= wr_ctrl && wr_data[bcp_pkg::CTRL_START];
			ctl.resume <= wr_ctrl && wr_data[bcp_pkg::CTRL_RESUME];
			ctl.stop <= wr_ctrl && wr_data[bcp_pkg::CTRL_STOP];
			if (wr_ctrl) begin
				ctl.step_mode <= wr_data[bcp_pkg::CTRL_STEP];
			end
			if (wr_en && hit_start) begin
				ctl.start_addr <= wr_data[15:0];
			end
		end
	end

	// Hardware set beats a software clear landing in the same cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			attention <= 1'b0;
			tip_switch_indicator <= 1'b0;
		end else begin
			if (ctl.set_attention_enable) begin
				attention <= 1'b1;
			end else if (wr_ctrl && wr_data[bcp_pkg::CTRL_CLR_ATTENTION_ENABLE]) begin
				attention <= 1'b0;
			end
			if (ctl.set_tsi) begin
				tip_switch_indicator <= 1'b1;
			end else if (wr_ctrl && wr_data[bcp_pkg::CTRL_CLR_TSI]) begin
				tip_switch_indicator <= 1'b0;
			end
		end
	end
endmodule : bcp_regs
`default_nettype wire

// *** tb/bcp_mem_model.sv ***
// Buffer storage model: one-cycle registered read, write on strobe
`timescale 1ns/1ns
`default_nettype none
module bcp_mem_model #(
	parameter int AW = 15
) (
	input wire logic clk_sys,
	input wire logic [AW-1:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [15:0] mem_wr_data,
	output var logic [15:0] mem_rd_data
);
	logic [15:0] mem [0:255];
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 16'h0000;
		end
		mem_rd_data = 16'h5a5a;
	end
	// Outside the answer cycle the data flips so a late capture cannot pass by luck
	always @(posedge clk_sys) begin
		if (mem_wr) begin
			mem[mem_addr[7:0]] <= mem_wr_data;
		end
		mem_rd_data <= mem_rd ? mem[mem_addr[7:0]] : ~mem_rd_data;
	end
endmodule : bcp_mem_model
`default_nettype wire

// *** tb/bcp_engine_properties.sv ***
// Port-level checker for the order engine
`timescale 1ns/1ns
`default_nettype none
module bcp_engine_properties #(
	parameter int AW = 15,
	parameter int CW = 12
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic reg_rd,
	input wire logic [AW-1:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [15:0] mem_wr_data,
	input wire logic [15:0] mem_rd_data,
	input wire logic [CW-1:0] beam_x,
	input wire logic [CW-1:0] beam_y,
	input wire logic [CW-1:0] tablet_x,
	input wire logic [CW-1:0] tablet_y,
	input wire logic tip_switch,
	input wire logic attention,
	input wire logic tip_switch_indicator
);
	// Last three fetched words: code, first operand, second operand
	logic [15:0] q0_r, q1_r, q2_r;
	logic [AW-1:0] rd_addr_r;
	logic rd_d_r, wr_d_r;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			{q0_r, q1_r, q2_r} <= '0;
			rd_addr_r <= '0;
			{rd_d_r, wr_d_r} <= 2'b00;
		end else begin
			rd_d_r <= mem_rd;
			wr_d_r <= mem_wr;
			if (mem_rd) rd_addr_r <= mem_addr;
			if (rd_d_r) {q0_r, q1_r, q2_r} <= {q1_r, q2_r, mem_rd_data};
		end
	end
	wire logic is_cnt = q0_r == bcp_pkg::OP_XFER_COUNT;
	wire logic [15:0] cnt_dec = q2_r - 16'h0001;
	wire logic [AW-1:0] exp_next = (cnt_dec != 16'h0000) ? q1_r[AW:1] : AW'(rd_addr_r + 1'b1);
	wire logic st_first = mem_wr && !wr_d_r && q0_r == bcp_pkg::OP_STORE_POS;
	wire logic attention_enable_cause = st_first && q1_r[bcp_pkg::OPT_ATTENTION_ENABLE];
	wire logic ind_cause = st_first && q1_r[bcp_pkg::OPT_SET_IND];
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_cnt_val; mem_wr && is_cnt |-> mem_wr_data == cnt_dec; endproperty
	a_cnt_val: assert property (p_cnt_val) else $error("count write-back value wrong");
	property p_cnt_addr; mem_wr && is_cnt |-> mem_addr == rd_addr_r; endproperty
	a_cnt_addr: assert property (p_cnt_addr) else $error("count written to wrong word");
	// Write-back, then the next-order step and a fresh fetch state, before the read strobe leaves the flop
	property p_cnt_next; mem_wr && is_cnt |=> !mem_rd [*2] ##1 (mem_rd && mem_addr == exp_next); endproperty
	a_cnt_next: assert property (p_cnt_next) else $error("wrong order fetched after count");
	property p_st_addr;
		st_first |-> mem_addr == q2_r[AW:1] ##1 (mem_wr && mem_addr == AW'(q2_r[AW:1] + 1'b1));
	endproperty
	a_st_addr: assert property (p_st_addr) else $error("position stored at wrong address");
	property p_st_src;
		st_first |-> mem_wr_data[CW-1:0] == (q1_r[bcp_pkg::OPT_TABLET] ? tablet_x : beam_x)
			##1 mem_wr_data[CW-1:0] == (q1_r[bcp_pkg::OPT_TABLET] ? tablet_y : beam_y);
	endproperty
	a_st_src: assert property (p_st_src) else $error("wrong coordinate source");
	property p_st_blank; st_first |-> mem_wr_data[bcp_pkg::BLANK_BIT] == q1_r[bcp_pkg::OPT_BLANK]; endproperty
	a_st_blank: assert property (p_st_blank) else $error("blanking bit wrong");
	property p_attention_enable_set; attention_enable_cause && tip_switch |=> attention; endproperty
	a_attention_enable_set: assert property (p_attention_enable_set) else $error("attention not raised");
	property p_attention_enable_only; $rose(attention) |-> $past(attention_enable_cause); endproperty
	a_attention_enable_only: assert property (p_attention_enable_only) else $error("attention without cause");
	property p_ind_set; ind_cause |=> tip_switch_indicator; endproperty
	a_ind_set: assert property (p_ind_set) else $error("indicator not set");
	property p_ind_only; $rose(tip_switch_indicator) |-> $past(ind_cause); endproperty
	a_ind_only: assert property (p_ind_only) else $error("indicator without cause");
	c_loop: cover property (mem_wr && is_cnt && cnt_dec != 16'h0000);
	c_wrap: cover property (mem_wr && is_cnt && q2_r == 16'h0000);
	c_tablet: cover property (st_first && q1_r[bcp_pkg::OPT_TABLET]);
endmodule : bcp_engine_properties
bind bcp_engine bcp_engine_properties #(.AW(AW), .CW(CW)) i_bcp_engine_properties (
	.clk_sys(clk_sys), .rstn(rstn), .reg_rd(reg_rd), .mem_addr(mem_addr), .mem_rd(mem_rd),
	.mem_wr(mem_wr), .mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data), .beam_x(beam_x),
	.beam_y(beam_y), .tablet_x(tablet_x), .tablet_y(tablet_y), .tip_switch(tip_switch),
	.attention(attention), .tip_switch_indicator(tip_switch_indicator)
);
`default_nettype wire

// *** tb/bcp_engine_bench.sv ***
// Testbench for the order engine: buffer program runs started over the register port
`timescale 1ns/1ns
`default_nettype none
module bcp_engine_bench;
	logic clk_sys, rstn, reg_wr, reg_rd, mem_rd, mem_wr, tip_switch, attention, tip_switch_indicator;
	logic [7:0] reg_addr;
	logic [31:0] reg_wr_data, reg_rd_data, d;
	logic [14:0] mem_addr;
	logic [15:0] mem_wr_data, mem_rd_data;
	logic [11:0] beam_x, beam_y, tablet_x, tablet_y, x, y;
	logic [15:0] opts [0:3] = '{16'h0000, 16'h0120, 16'h00c0, 16'h01e0};
	logic tips [0:3] = '{1'b1, 1'b1, 1'b1, 1'b0};
	int err_total = 0;
	int total_checks = 0;
	bcp_engine #(.AW(15), .CW(12)) i_bcp_engine (
		.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data),
		.beam_x(beam_x), .beam_y(beam_y), .tablet_x(tablet_x), .tablet_y(tablet_y),
		.tip_switch(tip_switch), .attention(attention), .tip_switch_indicator(tip_switch_indicator)
	);
	bcp_mem_model #(.AW(15)) i_bcp_mem_model (
		.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data)
	);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task reg_write(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wr_data <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_write
	task reg_read(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		v = reg_rd_data;
	endtask : reg_read
	// Start at a byte address and poll status until the engine goes idle
	task run(input logic [15:0] start);
		reg_write(bcp_pkg::REG_START, {16'h0000, start});
		reg_write(bcp_pkg::REG_CTRL, 32'h00000001);
		wait_idle();
	endtask : run
	task wait_idle;
		logic busy;
		int n;
		busy = 1'b1;
		n = 0;
		while (busy === 1'b1 && n < 100) begin
			reg_read(bcp_pkg::REG_STATUS, d);
			busy = d[bcp_pkg::ST_BUSY];
			n++;
		end
		if (busy !== 1'b0) begin
			err_total++;
			end_sim();
		end
	endtask : wait_idle
	initial begin
		{rstn, reg_wr, reg_rd, tip_switch} = 4'h0;
		reg_addr = 8'h00;
		reg_wr_data = 32'h0;
		{beam_x, beam_y, tablet_x, tablet_y} = '0;
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		// Self loop three times, then falls into a halting word
		i_bcp_mem_model.mem[0] = bcp_pkg::OP_XFER_COUNT;
		i_bcp_mem_model.mem[1] = 16'h0000;
		i_bcp_mem_model.mem[2] = 16'h0003;
		run(16'h0000);
		check(i_bcp_mem_model.mem[2], 32'h0);
		reg_read(bcp_pkg::REG_PC, d);
		check(d, 32'h6);
		reg_read(bcp_pkg::REG_STATUS, d);
		check(d[bcp_pkg::ST_BRANCH], 32'h0);
		check(d[bcp_pkg::ST_ERR], 32'h1);
		reg_read(bcp_pkg::REG_ORDERS, d);
		check(d, 32'h3);
		// Zero count wraps and branches; odd target bit dropped
		i_bcp_mem_model.mem[8] = bcp_pkg::OP_XFER_COUNT;
		i_bcp_mem_model.mem[9] = 16'h0021;
		i_bcp_mem_model.mem[10] = 16'h0000;
		run(16'h0010);
		check(i_bcp_mem_model.mem[10], 32'hffff);
		reg_read(bcp_pkg::REG_PC, d);
		check(d, 32'h20);
		reg_read(bcp_pkg::REG_STATUS, d);
		check(d[bcp_pkg::ST_BRANCH], 32'h1);
		// Store order with every option bit, tip both ways
		for (int i = 0; i < 4; i++) begin
			reg_write(bcp_pkg::REG_CTRL, 32'h0000000c);
			tip_switch <= tips[i];
			beam_x <= 12'h100 + 12'(i);
			beam_y <= 12'h210 + 12'(i);
			tablet_x <= 12'h5a0 + 12'(i);
			tablet_y <= 12'h6b0 + 12'(i);
			i_bcp_mem_model.mem[32] = bcp_pkg::OP_STORE_POS;
			i_bcp_mem_model.mem[33] = opts[i];
			i_bcp_mem_model.mem[34] = 16'h0080 + 16'(4 * i);
			run(16'h0040);
			x = opts[i][bcp_pkg::OPT_TABLET] ? tablet_x : beam_x;
			y = opts[i][bcp_pkg::OPT_TABLET] ? tablet_y : beam_y;
			check(i_bcp_mem_model.mem[64 + 2 * i], {opts[i][bcp_pkg::OPT_BLANK], 3'h0, x});
			check(i_bcp_mem_model.mem[65 + 2 * i], {4'h0, y});
			check(attention, opts[i][bcp_pkg::OPT_ATTENTION_ENABLE] & tips[i]);
			check(tip_switch_indicator, opts[i][bcp_pkg::OPT_SET_IND]);
			reg_read(bcp_pkg::REG_STATUS, d);
			check(d[bcp_pkg::ST_ATTENTION_ENABLE], opts[i][bcp_pkg::OPT_ATTENTION_ENABLE] & tips[i]);
			check(d[bcp_pkg::ST_TIP], tips[i]);
		end
		reg_read(8'h3c, d);
		check(d, 32'h0);
		reg_read(bcp_pkg::REG_START, d);
		check(d[15:0], 32'h40);
		// Step mode with the indicator cleared at start, then resume, then a stop while an order is in flight
		i_bcp_mem_model.mem[48] = bcp_pkg::OP_STORE_POS;
		i_bcp_mem_model.mem[49] = 16'h0040;
		i_bcp_mem_model.mem[50] = 16'h00a0;
		i_bcp_mem_model.mem[51] = bcp_pkg::OP_STORE_POS;
		i_bcp_mem_model.mem[52] = 16'h0020;
		i_bcp_mem_model.mem[53] = 16'h00a4;
		reg_write(bcp_pkg::REG_START, 32'h00000060);
		reg_write(bcp_pkg::REG_CTRL, 32'h00000019);
		wait_idle();
		check(tip_switch_indicator, 32'h1);
		check(i_bcp_mem_model.mem[80], {4'h0, beam_x});
		reg_read(bcp_pkg::REG_PC, d);
		check(d, 32'h66);
		reg_read(bcp_pkg::REG_ORDERS, d);
		check(d, 32'h9);
		reg_read(bcp_pkg::REG_CTRL, d);
		check(d, 32'h10);
		reg_write(bcp_pkg::REG_CTRL, 32'h00000038);
		wait_idle();
		check(tip_switch_indicator, 32'h0);
		check(i_bcp_mem_model.mem[82], {1'b1, 3'h0, beam_x});
		reg_read(bcp_pkg::REG_PC, d);
		check(d, 32'h6c);
		reg_write(bcp_pkg::REG_CTRL, 32'h00000001);
		reg_write(bcp_pkg::REG_CTRL, 32'h00000002);
		wait_idle();
		reg_read(bcp_pkg::REG_PC, d);
		check(d, 32'h66);
		reg_read(bcp_pkg::REG_STATUS, d);
		check(d[bcp_pkg::ST_ERR], 32'h0);
		reg_read(bcp_pkg::REG_LAST, d);
		check(d, {16'h0000, bcp_pkg::OP_STORE_POS});
		// Read data stands for one cycle only
		@(negedge clk_sys);
		check(reg_rd_data, 32'h0);
		end_sim();
	end
endmodule : bcp_engine_bench
`default_nettype wire
